//--- hw/cid_cfg.svh
`ifndef CID_CFG_SVH
`define CID_CFG_SVH
// Register byte offsets on the AXI4-Lite slave
`define CID_OFF_INSTR 8'h00
`define CID_OFF_SECOND 8'h04
`define CID_OFF_CTRL 8'h08
`define CID_OFF_FIELDS 8'h0C
`define CID_OFF_OPER 8'h10
`define CID_OFF_TARGET 8'h14
`define CID_OFF_PROGRAM_TABLE_POINTER 8'h18
`define CID_OFF_STATUS 8'h1C
// Control register bit positions
`define CID_CTRL_GO 0
`define CID_CTRL_BANK_LSB 4
`define CID_CTRL_COND_LSB 8
`define CID_CTRL_PORT 12
`define CID_CTRL_PSA 13
`define CID_CTRL_TIMER_ZERO_COUNT 14
// Reset values
`define CID_RST_PROGRAM_TABLE_POINTER 21'h000000
`define CID_RST_BANK 4'h0
// Opcode field positions
`define CID_DEST_BIT 9
`define CID_ACC_BIT 8
`define CID_SECOND_PREFIX 4'hF
`define CID_REG_TO_REG_MOVE_OPC 4'hC
// Oscillator periods per instruction cycle
`define CID_Q_PER_CYCLE 4
`endif

//--- hw/cid_decoder.sv
`include "cid_cfg.svh"
// Contract
// - Access bit picks access RAM or bank
// - Destination bit picks accumulator or file register
// - Three-bit field names bit zero to seven
// - Low byte is file address or pointer
// - Two-word move carries twelve-bit addresses
// - Table pointer 21 bits, four modes
// - Fast bit selects shadow save/restore
// - Lone 1111 second word is no-op
// - PC change or true test costs two; true skip tests take one cycle here
// - Port self-modify reads pin levels
// - Timer zero write clears its prescaler
// - Started table write runs to completion
// - Byte format: opcode, d, a, f
// - Literal format: opcode, eight-bit immediate
// - Absolute target is twenty bits, two words
// - Relative offsets eleven or eight bits signed
// - Conditional branch codes, one or two cycles
// - Add decodes and flags C DC Z OV N
// - Compare-skip, no flags, may skip
// - Bit operation nibbles, no flags changed
// - Watchdog kick and standby words
// - Return encodings, two cycles, fast bit
// - Four oscillator periods per instruction cycle
module cid_decoder
  import cid_pkg::*;
#(
  parameter int TBL_WIDTH = 21,
  parameter int Q_PER_CYCLE = `CID_Q_PER_CYCLE
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Pointer logic is sized for 21 bits and the phase counter holds at most 15
  if (TBL_WIDTH != 21 || Q_PER_CYCLE < 1 || Q_PER_CYCLE > 15) begin : g_param_check
    $error("cid_decoder: unsupported parameter values");
  end

  logic [15:0] instr_q;
  logic [15:0] second_q;
  logic [3:0] bank_q;
  logic [2:0] cond_q;
  logic port_q, psa_q, timer_zero_count_q;
  logic go;
  logic aw_seen_q, w_seen_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;

  // Write channel: address and data taken in either order, response after both
  assign s_axi_awready = !aw_seen_q && !s_axi_bvalid;
  assign s_axi_wready = !w_seen_q && !s_axi_bvalid;
  assign wr_fire = aw_seen_q && w_seen_q && !s_axi_bvalid;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      aw_seen_q <= 1'b0;
      w_seen_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_seen_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_seen_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_seen_q <= 1'b0;
        w_seen_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_q)
          `CID_OFF_INSTR, `CID_OFF_SECOND, `CID_OFF_CTRL: s_axi_bresp <= 2'b00;
          default: s_axi_bresp <= 2'b10;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Launch one cycle after the control write, so the decode sees the fields it wrote
  logic go_q;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      go_q <= 1'b0;
    end else begin
      go_q <= wr_fire && awaddr_q == `CID_OFF_CTRL && wstrb_q[0] && wdata_q[`CID_CTRL_GO];
    end
  end
  assign go = go_q;

  // Writable registers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      instr_q <= 16'h0000;
      second_q <= 16'h0000;
      bank_q <= `CID_RST_BANK;
      cond_q <= 3'h0;
      port_q <= 1'b0;
      psa_q <= 1'b0;
      timer_zero_count_q <= 1'b0;
    end else if (wr_fire) begin
      if (awaddr_q == `CID_OFF_INSTR) begin
        if (wstrb_q[0]) instr_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) instr_q[15:8] <= wdata_q[15:8];
      end
      if (awaddr_q == `CID_OFF_SECOND) begin
        if (wstrb_q[0]) second_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) second_q[15:8] <= wdata_q[15:8];
      end
      if (awaddr_q == `CID_OFF_CTRL) begin
        if (wstrb_q[0]) bank_q <= wdata_q[`CID_CTRL_BANK_LSB +: 4];
        if (wstrb_q[1]) begin
          cond_q <= wdata_q[`CID_CTRL_COND_LSB +: 3];
          port_q <= wdata_q[`CID_CTRL_PORT];
          psa_q <= wdata_q[`CID_CTRL_PSA];
          timer_zero_count_q <= wdata_q[`CID_CTRL_TIMER_ZERO_COUNT];
        end
      end
    end
  end

  // Combinational decode of the held instruction word
  cid_op_e op;
  logic [2:0] cyc_base, cyc_taken;
  logic flags_arith, flags_none, wdt_flags, two_word, pc_change;
  logic [3:0] hi4;
  logic [7:0] hi8;
  assign hi4 = instr_q[15:12];
  assign hi8 = instr_q[15:8];
  always_comb begin
    op = CID_OP_NOP;
    cyc_base = 3'd1;
    cyc_taken = 3'd1;
    flags_arith = 1'b0;
    flags_none = 1'b1;
    wdt_flags = 1'b0;
    two_word = 1'b0;
    pc_change = 1'b0;
    if (instr_q[15:10] == 6'b001000) begin
      op = CID_OP_ADDC;
      flags_arith = 1'b1;
      flags_none = 1'b0;
    end else if (instr_q[15:10] == 6'b001001) begin
      op = CID_OP_ADD;
      flags_arith = 1'b1;
      flags_none = 1'b0;
    end else if (instr_q[15:11] == 5'b01100 && instr_q[10:9] != 2'b11) begin
      op = CID_OP_CPSKIP; // Compare with accumulator
      cyc_taken = 3'd2;
    end else if (hi4 == 4'h9) begin
      op = CID_OP_BCLR;
    end else if (hi4 == 4'h8) begin
      op = CID_OP_BSET;
    end else if (hi4 == 4'hB) begin
      op = CID_OP_BTSC;
      cyc_taken = 3'd2;
    end else if (hi4 == 4'hA) begin
      op = CID_OP_BTSS;
      cyc_taken = 3'd2;
    end else if (hi4 == 4'h7) begin
      op = CID_OP_BTOG;
    end else if (instr_q[15:11] == 5'b11100) begin
      op = CID_OP_BCOND;
      cyc_taken = 3'd2;
    end else if (instr_q[15:11] == 5'b11010) begin
      op = CID_OP_BRA; // Always changes the counter
      cyc_base = 3'd2;
      cyc_taken = 3'd2;
      pc_change = 1'b1;
    end else if (instr_q[15:11] == 5'b11011) begin
      op = CID_OP_RELATIVE_SUBROUTINE_JUMP;
      cyc_base = 3'd2;
      cyc_taken = 3'd2;
      pc_change = 1'b1;
    end else if (instr_q[15:9] == 7'b1110110) begin
      op = CID_OP_CALL;
      cyc_base = 3'd2;
      cyc_taken = 3'd2;
      two_word = 1'b1;
      pc_change = 1'b1;
    end else if (hi8 == 8'hEF) begin
      op = CID_OP_GOTO;
      cyc_base = 3'd2;
      cyc_taken = 3'd2;
      two_word = 1'b1;
      pc_change = 1'b1;
    end else if (hi4 == `CID_REG_TO_REG_MOVE_OPC) begin
      op = CID_OP_REG_TO_REG_MOVE;
      cyc_base = 3'd2;
      cyc_taken = 3'd2;
      two_word = 1'b1;
    end else if (instr_q == 16'h0004) begin
      op = CID_OP_WDT;
      wdt_flags = 1'b1;
      flags_none = 1'b0;
    end else if (instr_q == 16'h0003) begin
      op = CID_OP_SLEEP;
      wdt_flags = 1'b1;
      flags_none = 1'b0;
    end else if (instr_q[15:1] == 15'h0008) begin
      op = CID_OP_RETURN_FROM_IRQ;
      cyc_base = 3'd2;
      cyc_taken = 3'd2;
      pc_change = 1'b1;
    end else if (instr_q[15:1] == 15'h0009) begin
      op = CID_OP_RETURN;
      cyc_base = 3'd2;
      cyc_taken = 3'd2;
      pc_change = 1'b1;
    end else if (instr_q[15:2] == 14'h0002) begin
      op = CID_OP_TBL; // Table read
      cyc_base = 3'd2;
      cyc_taken = 3'd2;
    end else if (instr_q[15:2] == 14'h0003) begin
      op = CID_OP_TBL; // Table write
      cyc_base = 3'd2;
      cyc_taken = 3'd2;
    end else if (hi8 == 8'h0E || hi8 == 8'h0F || hi8 == 8'h0B) begin
      op = CID_OP_LIT;
    end else if (hi4 == 4'h1 || hi4 == 4'h2 || hi4 == 4'h3 || hi4 == 4'h4
                 || hi4 == 4'h5 || instr_q[15:10] == 6'b000001) begin
      op = CID_OP_BYTE;
    end
    // Anything else, including a lone 1111 second word, stays a no-op
  end

  // Operand fields
  logic dest_file, use_bank;
  logic [2:0] bit_pos;
  logic [7:0] faddr;
  logic [11:0] src12, dst12;
  logic [19:0] abs_tgt;
  logic [20:0] rel_tgt;
  logic fast;
  assign dest_file = instr_q[`CID_DEST_BIT];
  assign use_bank = instr_q[`CID_ACC_BIT];
  assign bit_pos = instr_q[11:9];
  assign faddr = instr_q[7:0];
  assign src12 = instr_q[11:0];
  assign dst12 = second_q[11:0];
  assign abs_tgt = {second_q[11:0], instr_q[7:0]};
  assign fast = op == CID_OP_CALL ? instr_q[8] :
                ((op == CID_OP_RETURN_FROM_IRQ || op == CID_OP_RETURN) ? instr_q[0] : 1'b0);
  // Sign-extended word offset per branch family
  assign rel_tgt = op == CID_OP_BCOND ? {{13{instr_q[7]}}, instr_q[7:0]} :
                   {{10{instr_q[10]}}, instr_q[10:0]};

  // Bank address: access RAM ignores the bank selector
  logic [11:0] ram_addr;
  assign ram_addr = use_bank ? {bank_q, faddr} :
                    (faddr[7] ? {4'hF, faddr} : {4'h0, faddr});

  // Condition test for the eight branch codes
  logic cond_true;
  always_comb begin
    unique case (instr_q[10:8])
      3'b000: cond_true = cond_q[0];
      3'b001: cond_true = !cond_q[0];
      3'b010: cond_true = cond_q[1];
      3'b011: cond_true = !cond_q[1];
      3'b100: cond_true = cond_q[2];
      3'b101: cond_true = !cond_q[2];
      3'b110: cond_true = cond_q[0] && cond_q[1];
      3'b111: cond_true = !(cond_q[0] && cond_q[1]);
    endcase
  end

  // Execution timing: Q phases via a one-cycle enable, instruction cycles counted
  cid_state_e state_q;
  logic [3:0] q_cnt_q;
  logic [2:0] icyc_q, cycles_q;
  logic q_tick;
  logic [TBL_WIDTH-1:0] program_table_pointer_q;
  logic tbl_wr_busy_q, irq_reen_q, port_src_q, clr_presc_q;
  assign q_tick = q_cnt_q == 4'(Q_PER_CYCLE - 1);
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= CID_ST_IDLE;
      q_cnt_q <= 4'h0;
      icyc_q <= 3'd0;
      cycles_q <= 3'd0;
    end else begin
      unique case (state_q)
        CID_ST_IDLE, CID_ST_DONE: begin
          q_cnt_q <= 4'h0;
          icyc_q <= 3'd0;
          if (go) begin
            state_q <= CID_ST_EXEC;
            // Taken conditional branch or counter change adds a no-op cycle
            cycles_q <= (op == CID_OP_BCOND && cond_true) ? cyc_taken : cyc_base;
          end
        end
        CID_ST_EXEC: begin
          q_cnt_q <= q_tick ? 4'h0 : q_cnt_q + 4'h1;
          if (q_tick) begin
            icyc_q <= icyc_q + 3'd1;
            if (icyc_q + 3'd1 == cycles_q) state_q <= CID_ST_DONE;
          end
        end
        default: state_q <= CID_ST_IDLE;
      endcase
    end
  end

  // Byte-oriented writes back to the file, adds included, may hit a port or the timer
  logic file_write_op;
  assign file_write_op = dest_file && (op inside {CID_OP_BYTE, CID_OP_ADD, CID_OP_ADDC});

  // Side effects: table pointer modes, write completion, irq, port and prescaler
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      program_table_pointer_q <= `CID_RST_PROGRAM_TABLE_POINTER;
      tbl_wr_busy_q <= 1'b0;
      irq_reen_q <= 1'b0;
      port_src_q <= 1'b0;
      clr_presc_q <= 1'b0;
    end else begin
      if (go && op == CID_OP_TBL) begin
        unique case (cid_tmode_e'(instr_q[1:0]))
          CID_TM_NONE: program_table_pointer_q <= program_table_pointer_q;
          CID_TM_POSTINC, CID_TM_PREINC: program_table_pointer_q <= program_table_pointer_q + 21'd1;
          CID_TM_POSTDEC: program_table_pointer_q <= program_table_pointer_q - 21'd1;
        endcase
        // A started write is never cut short by the next decode
        if (instr_q[2]) tbl_wr_busy_q <= 1'b1;
      end else if (tbl_wr_busy_q && state_q == CID_ST_DONE) begin
        tbl_wr_busy_q <= 1'b0;
      end
      if (go) begin
        irq_reen_q <= op == CID_OP_RETURN_FROM_IRQ;
        port_src_q <= port_q && file_write_op;
        clr_presc_q <= timer_zero_count_q && psa_q && file_write_op;
      end
    end
  end

  // Read channel
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      `CID_OFF_INSTR: rd_word = {16'h0000, instr_q};
      `CID_OFF_SECOND: rd_word = {16'h0000, second_q};
      `CID_OFF_CTRL: rd_word = {17'h0, timer_zero_count_q, psa_q, port_q, 1'b0, cond_q, bank_q, 4'h0};
      `CID_OFF_FIELDS: rd_word = {7'h00, ram_addr, faddr, bit_pos, dest_file, use_bank};
      `CID_OFF_OPER: rd_word = {src12, dst12, 1'b0, two_word, pc_change, op};
      `CID_OFF_TARGET: rd_word = op inside {CID_OP_BCOND, CID_OP_BRA, CID_OP_RELATIVE_SUBROUTINE_JUMP} ?
                                 {11'h0, rel_tgt} : {12'h0, abs_tgt};
      `CID_OFF_PROGRAM_TABLE_POINTER: rd_word = {11'h0, program_table_pointer_q};
      `CID_OFF_STATUS: rd_word = {16'h0, fast, clr_presc_q, port_src_q, irq_reen_q,
                                  tbl_wr_busy_q, wdt_flags, flags_none, flags_arith,
                                  cycles_q, cond_true, state_q, 2'b00};
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  a_bank_select: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !use_bank |-> ram_addr[11:8] == 4'h0 || ram_addr[11:8] == 4'hF) else $error("bank leak");
  a_dest_field: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    dest_file == instr_q[9]) else $error("dest bit wrong");
  a_add_flags: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    instr_q[15:11] == 5'b00100 |-> flags_arith) else $error("add flags missing");
  a_bit_noflag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (op inside {CID_OP_BSET, CID_OP_BCLR, CID_OP_BTOG}) |-> !flags_arith && flags_none)
    else $error("bit op flags");
  a_lone_second: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hi4 == `CID_SECOND_PREFIX |-> op == CID_OP_NOP) else $error("second word not nop");
  a_taken_two: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    go && op == CID_OP_BCOND && cond_true |=> cycles_q == 3'd2) else $error("taken cycles");
  a_q_length: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == CID_ST_EXEC && $rose(state_q == CID_ST_EXEC) && cycles_q == 3'd1
    |-> ##4 state_q == CID_ST_DONE) else $error("cycle length");
  a_watchdog_word: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    instr_q == 16'h0004 |-> op == CID_OP_WDT && wdt_flags) else $error("watchdog decode");
  a_ret_cycles: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    go && op == CID_OP_RETURN |=> cycles_q == 3'd2) else $error("return cycles");
  c_branch_taken: cover property (@(posedge clk_i) go && op == CID_OP_BCOND && cond_true);
  c_table_write: cover property (@(posedge clk_i) go && op == CID_OP_TBL && instr_q[2]);
  c_move_two: cover property (@(posedge clk_i) go && op == CID_OP_REG_TO_REG_MOVE);
endmodule

//--- hw/cid_pkg.sv
package cid_pkg;
  typedef enum logic [4:0] {
    CID_OP_NOP = 5'h00,
    CID_OP_ADDC = 5'h01,
    CID_OP_ADD = 5'h02,
    CID_OP_BYTE = 5'h03,
    CID_OP_CPSKIP = 5'h04,
    CID_OP_BCLR = 5'h05,
    CID_OP_BSET = 5'h06,
    CID_OP_BTSC = 5'h07,
    CID_OP_BTSS = 5'h08,
    CID_OP_BTOG = 5'h09,
    CID_OP_BCOND = 5'h0A,
    CID_OP_BRA = 5'h0B,
    CID_OP_RELATIVE_SUBROUTINE_JUMP = 5'h0C,
    CID_OP_CALL = 5'h0D,
    CID_OP_GOTO = 5'h0E,
    CID_OP_REG_TO_REG_MOVE = 5'h0F,
    CID_OP_WDT = 5'h10,
    CID_OP_SLEEP = 5'h11,
    CID_OP_RETURN_FROM_IRQ = 5'h12,
    CID_OP_RETURN = 5'h13,
    CID_OP_LIT = 5'h14,
    CID_OP_TBL = 5'h15
  } cid_op_e;
  typedef enum logic [1:0] {
    CID_TM_NONE = 2'b00,
    CID_TM_POSTINC = 2'b01,
    CID_TM_POSTDEC = 2'b10,
    CID_TM_PREINC = 2'b11
  } cid_tmode_e;
  typedef enum logic [1:0] {
    CID_ST_IDLE = 2'b00,
    CID_ST_EXEC = 2'b01,
    CID_ST_DONE = 2'b10
  } cid_state_e;
endpackage

//--- testbench/cid_prog_mem.sv
module cid_prog_mem (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic req_i,
  input wire logic slow_i,
  input wire logic [7:0] addr_i,
  output logic [15:0] word_o,
  output logic valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [256];
  logic [15:0] data_q;
  logic [1:0] wait_q;
  // Preload hook used by the bench
  task automatic load(input logic [7:0] a, input logic [15:0] w);
    mem[a] = w;
  endtask
  // One word per request, after one cycle or three when slow
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || valid_o || !req_i) begin
      valid_o <= 1'h0;
      wait_q <= 2'h0;
    end else if (wait_q == (slow_i ? 2'h2 : 2'h0)) begin
      valid_o <= 1'h1;
      data_q <= mem[addr_i];
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
  // Released bus shows the inverse so stale data never passes as a word
  assign word_o = valid_o ? data_q : ~data_q;
endmodule

//--- testbench/tb.sv
`include "cid_cfg.svh"
module tb import cid_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, paddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, pvalid;
  logic req = 1'h0, slow = 1'h0;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h5862, st, first, fld, opr, tgt, d, v;
  logic [1:0] bresp, rresp, r;
  logic [15:0] pword, w;
  logic [20:0] ptr;
  logic [3:0] nibs [5] = '{4'h9, 4'h8, 4'hB, 4'hA, 4'h7};
  logic [15:0] ctl [12] = '{16'hD7FF, 16'hD801, 16'h0004, 16'h0003, 16'h0010, 16'h0011,
    16'h0012, 16'h0013, 16'hF123, 16'h0002, 16'h0E5A, 16'h6201};
  logic [15:0] tbl [6] = '{16'h000A, 16'h0009, 16'h0009, 16'h0008, 16'h000B, 16'h000D};
  int fail_count = 0, samples_checked = 0, cyc = 0;

  // Core clock, 40 ns period
  always #20 clk_i = ~clk_i;

  cid_decoder #(.TBL_WIDTH(21), .Q_PER_CYCLE(`CID_Q_PER_CYCLE)) u_cid_decoder (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  cid_prog_mem u_cid_prog_mem (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req),
    .slow_i(slow), .addr_i(paddr), .word_o(pword), .valid_o(pvalid));

  // Xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic cid_op_e exp_op(input logic [15:0] x);
    casez (x)
      16'h0002: return CID_OP_NOP;
      16'h0003: return CID_OP_SLEEP;
      16'h0004: return CID_OP_WDT;
      16'b0000_0000_0001_000?: return CID_OP_RETURN_FROM_IRQ;
      16'b0000_0000_0001_001?: return CID_OP_RETURN;
      16'b0000_0000_0000_1???: return CID_OP_TBL;
      16'h0E??, 16'h0F??, 16'h0B??: return CID_OP_LIT;
      16'hF???: return CID_OP_NOP;
      16'hC???: return CID_OP_REG_TO_REG_MOVE;
      16'b1110_0???_????_????: return CID_OP_BCOND;
      16'b1110_110?_????_????: return CID_OP_CALL;
      16'hEF??: return CID_OP_GOTO;
      16'b1101_0???_????_????: return CID_OP_BRA;
      16'b1101_1???_????_????: return CID_OP_RELATIVE_SUBROUTINE_JUMP;
      16'h9???: return CID_OP_BCLR;
      16'h8???: return CID_OP_BSET;
      16'hB???: return CID_OP_BTSC;
      16'hA???: return CID_OP_BTSS;
      16'h7???: return CID_OP_BTOG;
      16'b0110_001?_????_????: return CID_OP_CPSKIP;
      16'b0010_00??_????_????: return CID_OP_ADDC;
      16'b0010_01??_????_????: return CID_OP_ADD;
      default: return CID_OP_BYTE;
    endcase
  endfunction

  // Program-counter changers and taken conditional branches cost a second cycle
  function automatic logic [2:0] exp_cyc(input logic [15:0] x, input logic t);
    case (exp_op(x))
      CID_OP_BCOND: return t ? 3'h2 : 3'h1;
      CID_OP_BRA, CID_OP_RELATIVE_SUBROUTINE_JUMP, CID_OP_CALL, CID_OP_GOTO, CID_OP_REG_TO_REG_MOVE, CID_OP_RETURN_FROM_IRQ,
      CID_OP_RETURN, CID_OP_TBL: return 3'h2;
      default: return 3'h1;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Handshakes are judged at the falling edge, where nothing moves, and end on the rising one
  task automatic axw(input logic [7:0] a, input logic [31:0] x, output logic [1:0] rs);
    logic ta, tw, tb;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk_i);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge clk_i);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
    end while (!tb);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rs);
    logic ta, tr;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clk_i);
      ta = arvalid && arready;
      tr = rvalid;
      x = rdata;
      rs = rresp;
      @(posedge clk_i);
      if (ta) arvalid <= 1'h0;
      if (tr) rready <= 1'h0;
    end while (!tr);
  endtask

  task automatic fetch(input logic [7:0] a, output logic [15:0] x);
    logic ok;
    logic [31:0] sv;
    @(posedge clk_i);
    sv = rnd();
    req <= 1'h1;
    paddr <= a;
    slow <= sv[0];
    do begin
      @(negedge clk_i);
      ok = pvalid;
      x = pword;
      @(posedge clk_i);
    end while (!ok);
    req <= 1'h0;
  endtask

  // Fetch both words, load them, start and poll until finished
  task automatic run(input logic [15:0] w1, input logic [15:0] w2, input logic [31:0] c);
    logic [15:0] a, b;
    int n;
    u_cid_prog_mem.load(8'h00, w1);
    u_cid_prog_mem.load(8'h01, w2);
    fetch(8'h00, a);
    fetch(8'h01, b);
    axw(`CID_OFF_INSTR, {16'h0000, a}, r);
    axw(`CID_OFF_SECOND, {16'h0000, b}, r);
    axw(`CID_OFF_CTRL, c | 32'h1, r);
    axr(`CID_OFF_STATUS, first, r);
    st = first;
    n = 0;
    while (st[3:2] !== 2'h2 && n < 100) begin
      axr(`CID_OFF_STATUS, st, r);
      n++;
    end
    chk(32'(st[3:2]), 32'h2, "finished");
    axr(`CID_OFF_FIELDS, fld, r);
    axr(`CID_OFF_OPER, opr, r);
    axr(`CID_OFF_TARGET, tgt, r);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("ERROR %0t timeout", $time);
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'h1;
    axr(`CID_OFF_PROGRAM_TABLE_POINTER, d, r);
    chk(d, 32'h0, "pointer reset");
    axr(8'h20, d, r);
    chk({r, d[29:0]}, 32'h80000000, "unmapped read");
    axw(`CID_OFF_FIELDS, 32'h0, r);
    chk(32'(r), 32'h2, "read-only write");
    // Adds with random field values and bank
    repeat (6) begin
      v = rnd();
      w = {5'h04, v[10:0]};
      run(w, 16'h0000, {24'h0, v[15:12], 4'h0});
      chk(32'(opr[4:0]), 32'(exp_op(w)), "add op");
      chk(32'(fld[12:5]), 32'(w[7:0]), "file addr");
      chk(32'(fld[1:0]), 32'(w[9:8]), "d and a");
      if (w[8]) chk(32'(fld[24:13]), {20'h0, v[15:12], w[7:0]}, "banked addr");
      chk(32'(st[8]), 32'h1, "arith flags");
      chk(32'(st[7:5]), 32'h1, "one cycle");
    end
    // Every bit operation
    for (int i = 0; i < 5; i++) begin
      v = rnd();
      w = {nibs[i], v[11:0]};
      run(w, 16'h0000, 32'h0);
      chk(32'(opr[4:0]), 32'(exp_op(w)), "bit op");
      chk(32'(fld[4:2]), 32'(w[11:9]), "bit pos");
      chk(32'(st[9]), 32'h1, "no flags");
    end
    // Every branch condition; test and cycles checked against random flags for codes 0 to 5
    for (int c = 0; c < 8; c++) begin
      v = rnd();
      w = {5'h1C, 3'(c), v[7:0]};
      run(w, 16'h0000, {21'h0, v[10:8], 8'h00});
      chk(32'(opr[4:0]), 32'(exp_op(w)), "cond op");
      chk(tgt, {11'h0, {13{w[7]}}, w[7:0]}, "cond offset");
      if (c < 6) begin
        chk(32'(st[4]), 32'(v[8 + c / 2] ^ c[0]), "cond test");
        chk(32'(st[7:5]), 32'(exp_cyc(w, v[8 + c / 2] ^ c[0])), "cond cycles");
      end
    end
    // Single-word control, stray and undefined words
    for (int i = 0; i < 12; i++) begin
      w = ctl[i];
      run(w, 16'h0000, 32'h0);
      chk(32'(opr[4:0]), 32'(exp_op(w)), "ctl op");
      if (exp_op(w) inside {CID_OP_BRA, CID_OP_RELATIVE_SUBROUTINE_JUMP})
        chk(tgt, {11'h0, {10{w[10]}}, w[10:0]}, "rel target");
      if (exp_op(w) != CID_OP_CPSKIP) chk(32'(st[7:5]), 32'(exp_cyc(w, 1'h0)), "cycles");
      else chk(32'(st[9]), 32'h1, "skip no flags");
      if (exp_op(w) inside {CID_OP_RETURN_FROM_IRQ, CID_OP_RETURN}) begin
        chk(32'(st[15]), 32'(w[0]), "fast bit");
        chk(32'(st[12]), 32'(exp_op(w) == CID_OP_RETURN_FROM_IRQ), "irq reenable");
      end
    end
    // Two-word absolute jumps and the register move
    v = rnd();
    run({8'hEF, v[7:0]}, {4'hF, v[19:8]}, 32'h0);
    chk(32'(tgt[19:0]), 32'(v[19:0]), "goto target");
    run({8'hED, v[27:20]}, {4'hF, v[31:20]}, 32'h0);
    chk(32'(tgt[19:0]), {12'h0, v[31:20], v[27:20]}, "call target");
    chk(32'(st[15]), 32'h1, "call fast");
    run({4'hC, v[11:0]}, {4'hF, v[23:12]}, 32'h0);
    chk(32'(first[3:2]), 32'h1, "still busy");
    chk({8'h0, opr[31:8]}, {8'h0, v[11:0], v[23:12]}, "move addrs");
    chk(32'(opr[6]), 32'h1, "two words");
    // Table pointer walk, wrapping below zero first
    ptr = 21'h0;
    for (int i = 0; i < 6; i++) begin
      run(tbl[i], 16'h0000, 32'h0);
      if (tbl[i][1:0] == 2'h2) ptr = ptr - 21'h1;
      else if (tbl[i][1:0] != 2'h0) ptr = ptr + 21'h1;
      axr(`CID_OFF_PROGRAM_TABLE_POINTER, d, r);
      chk(d, {11'h0, ptr}, "table pointer");
    end
    // Port source and prescaler clear, with and without write-back
    run(16'h2655, 16'h0000, 32'h7000);
    chk(32'(st[14:13]), 32'h3, "port and prescaler");
    run(16'h2455, 16'h0000, 32'h6000);
    chk(32'(st[14:13]), 32'h0, "no clear to acc");
    end_of_test();
  end
endmodule
